// *** tkd_core.sv ***
// detection integrator, output modes, on-duration timeout and neighbour suppression
`timescale 1ns/1ps
module tkd_core
  import tkd_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = tkd_pkg::CYCLE_CLKS               // clocks per acquisition cycle
)
(
  input  wire logic                              mclk,            // 10 MHz system clock
  input  wire logic                              srst,            // synchronous reset, active high
  input  wire logic                              recal_pin_n,     // recalibration input, active low
  input  wire tkd_pkg::tkd_strap_s               strap_pins,      // strap_select_a / strap_select_b
  input  wire logic                              suppress_en,     // neighbour_key_suppression variant
  input  wire tkd_pkg::tkd_sample_s [tkd_pkg::NUM_KEYS-1:0] sample, // raw levels, same clock domain
  input  wire logic                              burst_busy,      // acquisition still bursting
  output logic [tkd_pkg::NUM_KEYS-1:0]           key_out,         // key outputs, high = touched
  output logic                                   cycle_tick       // acquisition cycle strobe
);
  import tkd_pkg::*;

  // ************************************************************
  // constants and helpers
  // ************************************************************
  localparam logic [SIG_W-1:0] THR_V  = SIG_W'(THRESH_CNT);        // threshold in signal counts
  localparam logic [SIG_W-1:0] HYS_V  = SIG_W'(THRESH_CNT - HYST_CNT); // release level

  // ring neighbours of key k
  function automatic int unsigned nb_lo(input int unsigned k);
    nb_lo = (k == 0) ? NUM_KEYS - 1 : k - 1;
  endfunction

  function automatic int unsigned nb_hi(input int unsigned k);
    nb_hi = (k == NUM_KEYS - 1) ? 0 : k + 1;
  endfunction

  // signal above reference, saturating at zero
  function automatic logic [SIG_W-1:0] delta(input logic [SIG_W-1:0] lvl, input logic [SIG_W-1:0] ref_v);
    delta = (lvl > ref_v) ? lvl - ref_v : '0;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic       recal_meta_q;                                        // first stage, read by second only
  logic       recal_sync_q;                                        // synchronised reset pin
  tkd_strap_s strap_meta_q;                                        // first stage of strap pins
  tkd_strap_s strap_sync_q;                                        // synchronised strap pins

  // two flops per pin; strap pins are slow but still asynchronous
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      recal_meta_q <= 1'b1;
      recal_sync_q <= 1'b1;
      strap_meta_q <= '0;
      strap_sync_q <= '0;
    end
    else
    begin
      recal_meta_q <= recal_pin_n;
      recal_sync_q <= recal_meta_q;
      strap_meta_q <= strap_pins;
      strap_sync_q <= strap_meta_q;
    end
  end

  // ************************************************************
  // recalibration request from the pin
  // ************************************************************
  logic [15:0] low_cnt_q;                                          // clocks the pin has been low
  logic        pin_recal_q;                                        // pending pin-driven recal

  // a short glitch below the documented width is ignored; recal fires on release
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      low_cnt_q   <= '0;
      pin_recal_q <= 1'b1;
    end
    else if (!recal_sync_q)
    begin
      if (low_cnt_q != 16'hFFFF)
        low_cnt_q <= low_cnt_q + 16'h0001;
    end
    else
    begin
      // pulse long enough arms a full recalibration
      if (low_cnt_q >= 16'(RECAL_PULSE_CLKS))
        pin_recal_q <= 1'b1;
      else if (cycle_tick)
        pin_recal_q <= 1'b0;
      low_cnt_q <= '0;
    end
  end

  // ************************************************************
  // acquisition cycle timer
  // ************************************************************
  logic [21:0] cyc_cnt_q;                                          // clocks within current cycle
  logic        tick_q;                                             // one-clock cycle strobe

  // cycle closes only after its period and once bursts finish, so long bursts stretch it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cyc_cnt_q <= '0;
      tick_q    <= 1'b0;
    end
    else if (cyc_cnt_q >= 22'(CYCLE_LEN - 1) && !burst_busy)
    begin
      cyc_cnt_q <= '0;
      tick_q    <= 1'b1;
    end
    else
    begin
      if (cyc_cnt_q != 22'h3F_FFFF)
        cyc_cnt_q <= cyc_cnt_q + 22'h00_0001;
      tick_q <= 1'b0;
    end
  end

  assign cycle_tick = tick_q;

  // ************************************************************
  // strap mode, resampled per cycle
  // ************************************************************
  tkd_mode_e mode_q;                                               // active output mode

  // decode straps on every cycle boundary so changes take effect live
  always_ff @(posedge mclk)
  begin
    if (srst)
      mode_q <= TKD_MODE_DC_INF;
    else if (tick_q)
    begin
      if (!strap_sync_q.a && strap_sync_q.b)
        mode_q <= TKD_MODE_DC_10;
      else if (strap_sync_q.a && !strap_sync_q.b)
        mode_q <= TKD_MODE_DC_60;
      else if (strap_sync_q.a && strap_sync_q.b)
        mode_q <= TKD_MODE_TOGGLE;
      else
        mode_q <= TKD_MODE_DC_INF;
    end
  end

  // ************************************************************
  // per-channel state
  // ************************************************************
  logic [SIG_W-1:0]  ref_q   [NUM_KEYS];                           // reference level
  logic [SIG_W-1:0]  lvl_q   [NUM_KEYS];                           // latest raw level
  logic [1:0]        integ_q [NUM_KEYS];                           // detection integrator
  logic [TMO_W-1:0]  tmo_q   [NUM_KEYS];                           // on-duration timer
  logic [NUM_KEYS-1:0] det_q;                                      // integrated detection in effect
  logic [NUM_KEYS-1:0] out_q;                                      // output flops
  logic [NUM_KEYS-1:0] recal_q;                                    // channel recal on next tick
  logic [3:0]        drift_q;                                      // drift step prescaler

  logic [NUM_KEYS-1:0] above;                                      // level above threshold
  logic [NUM_KEYS-1:0] hold;                                       // level above hysteresis
  logic [NUM_KEYS-1:0] supp;                                       // suppressed by a neighbour
  logic [NUM_KEYS-1:0] tmo_hit;                                    // on-duration expired

  // comparisons against reference, neighbour check and timer limit
  always_comb
  begin
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      above[k] = delta(lvl_q[k], ref_q[k]) >= THR_V;
      hold[k]  = delta(lvl_q[k], ref_q[k]) >= HYS_V;
      // neighbour already reporting, or stronger right now
      supp[k]  = suppress_en &&
                 (out_q[nb_lo(k)] || out_q[nb_hi(k)] ||
                  delta(lvl_q[nb_lo(k)], ref_q[nb_lo(k)]) > delta(lvl_q[k], ref_q[k]) ||
                  delta(lvl_q[nb_hi(k)], ref_q[nb_hi(k)]) > delta(lvl_q[k], ref_q[k]));
      case (mode_q)
        TKD_MODE_DC_10,
        TKD_MODE_TOGGLE: tmo_hit[k] = tmo_q[k] >= TMO_W'(TMO_SHORT_CYC);
        TKD_MODE_DC_60:  tmo_hit[k] = tmo_q[k] >= TMO_W'(TMO_LONG_CYC);
        default:         tmo_hit[k] = 1'b0;
      endcase
    end
  end

  // latch raw samples as they arrive
  always_ff @(posedge mclk)
  begin
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      if (srst)
        lvl_q[k] <= '0;
      else if (sample[k].valid)
        lvl_q[k] <= sample[k].level;
    end
  end

  // drift prescaler, counted in acquisition cycles
  always_ff @(posedge mclk)
  begin
    if (srst)
      drift_q <= '0;
    else if (tick_q)
      drift_q <= (drift_q == 4'(DRIFT_DIV - 1)) ? 4'h0 : drift_q + 4'h1;
  end

  // ************************************************************
  // integrator, outputs, timers, reference
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      if (srst)
      begin
        integ_q[k] <= '0;
        tmo_q[k]   <= '0;
        det_q[k]   <= 1'b0;
        out_q[k]   <= 1'b0;
        recal_q[k] <= 1'b1;
        ref_q[k]   <= '0;
      end
      else if (tick_q)
      begin
        if (pin_recal_q || recal_q[k])
        begin
          // full recalibration: reference snaps to level; toggle state survives a channel recal but a pin recal clears it
          ref_q[k]   <= lvl_q[k];
          integ_q[k] <= '0;
          tmo_q[k]   <= '0;
          det_q[k]   <= 1'b0;
          recal_q[k] <= 1'b0;
          if (mode_q != TKD_MODE_TOGGLE || pin_recal_q)
            out_q[k] <= 1'b0;
        end
        else if (!det_q[k])
        begin
          if (above[k] && !supp[k])
          begin
            if (integ_q[k] == 2'(INTEG_LIMIT - 1))
            begin
              det_q[k]   <= 1'b1;
              integ_q[k] <= '0;
              if (mode_q == TKD_MODE_TOGGLE)
                out_q[k] <= ~out_q[k];
              else
                out_q[k] <= 1'b1;
            end
            else
              integ_q[k] <= integ_q[k] + 2'b01;
          end
          else
            integ_q[k] <= '0;
          // drift only while idle and not a held suppressed key
          if (!(above[k] && supp[k]) && (drift_q == '0 || lvl_q[k] < ref_q[k]))
          begin
            if (lvl_q[k] > ref_q[k])
              ref_q[k] <= ref_q[k] + SIG_W'(1);
            else if (lvl_q[k] < ref_q[k])
              ref_q[k] <= ref_q[k] - SIG_W'(1);
          end
        end
        else
        begin
          // detection in effect: hold or release with hysteresis
          if (!hold[k])
          begin
            det_q[k] <= 1'b0;
            tmo_q[k] <= '0;
            if (mode_q != TKD_MODE_TOGGLE)
              out_q[k] <= 1'b0;
          end
          else if (tmo_hit[k])
            recal_q[k] <= 1'b1;
          else if (tmo_q[k] != '1)
            tmo_q[k] <= tmo_q[k] + TMO_W'(1);
        end
      end
    end
  end

  assign key_out = out_q;

endmodule // tkd_core

// *** tkd_pkg.sv ***
// package of constants and carrier types for the touch key detect and output block
package tkd_pkg;

  localparam int unsigned NUM_KEYS      = 6;                       // sensing channels
  localparam int unsigned SIG_W         = 14;                      // acquisition resolution, bits
  localparam int unsigned CLK_HZ        = 10_000_000;              // mclk rate
  localparam int unsigned INTEG_LIMIT   = 3;                       // consecutive detections to assert
  localparam int unsigned THRESH_CNT    = 6;                       // detect threshold above reference
  localparam int unsigned HYST_CNT      = 2;                       // hysteresis below threshold
  localparam int unsigned CYCLE_MS      = 33;                      // acquisition cycle period, ms
  localparam int unsigned RESP_MS       = 99;                      // response time at 10 MHz, ms
  localparam int unsigned TMO_SHORT_S   = 10;                      // short on-duration limit, s
  localparam int unsigned TMO_LONG_S    = 60;                      // long on-duration limit, s
  localparam int unsigned RECAL_PULSE_NS = 5_000;                  // least reset-pin low time, ns
  localparam int unsigned DRIFT_DIV     = 16;                      // acquisition cycles per upward drift step

  // cycle counts derived from the times above
  localparam int unsigned CYCLE_CLKS    = (CLK_HZ / 1000) * CYCLE_MS;         // clocks per acquisition cycle
  localparam int unsigned TMO_SHORT_CYC = (TMO_SHORT_S * 1000) / CYCLE_MS;    // acq cycles for 10 s
  localparam int unsigned TMO_LONG_CYC  = (TMO_LONG_S * 1000) / CYCLE_MS;     // acq cycles for 60 s
  localparam int unsigned RECAL_PULSE_CLKS = (RECAL_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int unsigned TMO_W = 11;                              // on-duration counter width

  // strap decode result
  typedef enum logic [1:0] {
    TKD_MODE_DC_10,
    TKD_MODE_DC_60,
    TKD_MODE_TOGGLE,
    TKD_MODE_DC_INF
  } tkd_mode_e;

  // one channel's raw acquisition result
  typedef struct packed {
    logic             valid;                                       // new sample this cycle
    logic [SIG_W-1:0] level;                                       // raw signal level
  } tkd_sample_s;

  // the two strap pins
  typedef struct packed {
    logic a;                                                       // strap_select_a
    logic b;                                                       // strap_select_b
  } tkd_strap_s;

endpackage : tkd_pkg

// *** tkd_props.sv ***
// concurrent checks on the ports of the touch key detect core
`timescale 1ns/1ps
module tkd_props
  import tkd_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = tkd_pkg::CYCLE_CLKS  // clocks per acquisition cycle
)
(
  input wire logic                              mclk,         // system clock
  input wire logic                              srst,         // sync reset
  input wire logic                              recal_pin_n,  // recal pin, low active
  input wire tkd_pkg::tkd_strap_s               strap_pins,   // straps
  input wire logic                              suppress_en,  // ring variant
  input wire tkd_pkg::tkd_sample_s [tkd_pkg::NUM_KEYS-1:0] sample, // raw levels
  input wire logic                              burst_busy,   // bursting
  input wire logic [tkd_pkg::NUM_KEYS-1:0]      key_out,      // key outputs
  input wire logic                              cycle_tick    // cycle strobe
);
  localparam int GAP_MIN = int'(CYCLE_LEN) - 2; // slack of one clock for launch
  localparam int GAP_MAX = int'(CYCLE_LEN) + 2;
  logic [19:0] gap_q;                          // clocks since last tick
  logic        busy_seen_q;                    // a burst stretched this gap
  logic [7:0]  low_q;                          // clocks the pin has been low
  logic        pend_q;                         // long pin pulse waiting for a tick

  // ****************************************
  // helper counters
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst || cycle_tick)
    begin
      gap_q       <= '0;
      busy_seen_q <= 1'b0;
    end
    else
    begin
      gap_q       <= gap_q + 20'h0_0001;
      busy_seen_q <= busy_seen_q | burst_busy;
    end
  end

  // pulse width is judged with margin for the two sync flops
  always_ff @(posedge mclk)
  begin
    if (srst || recal_pin_n)
      low_q <= '0;
    else if (low_q != 8'hff)
      low_q <= low_q + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (srst || cycle_tick)
      pend_q <= 1'b0;
    else if (recal_pin_n && low_q >= 8'd52)
      pend_q <= 1'b1;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence pin_armed;
    pend_q && $past(pend_q, 4);
  endsequence

  sequence outputs_clear;
    ##[1:2] key_out == '0;
  endsequence

  chk_reset_quiet: assert property ($fell(srst) |-> key_out == '0 && !cycle_tick)
    else $error("outputs not idle after reset");
  chk_tick_pulse: assert property (cycle_tick |=> !cycle_tick)
    else $error("cycle strobe longer than one clock");
  chk_tick_spacing: assert property (cycle_tick |-> gap_q >= GAP_MIN)
    else $error("acquisition cycle too short");
  chk_tick_late: assert property (!busy_seen_q |-> gap_q <= GAP_MAX)
    else $error("acquisition cycle overran without bursting");
  chk_busy_hold: assert property ($past(burst_busy) |-> !cycle_tick)
    else $error("cycle ended while bursting");
  chk_key_on_tick: assert property ($changed(key_out) |-> $past(cycle_tick) || $past(cycle_tick, 2))
    else $error("key output moved between decisions");
  chk_ring_pairs: assert property (suppress_en && $past(suppress_en)
                                   |-> (key_out & {key_out[4:0], key_out[5]}) == '0)
    else $error("two neighbouring keys active together");
  chk_recal_clear: assert property (pin_armed and cycle_tick |-> outputs_clear)
    else $error("pin recalibration left an output active");
endmodule // tkd_props

// *** tkd_partner.sv ***
// host side model: reads the key outputs and can pulse the recal pin
`timescale 1ns/1ps
module tkd_partner (
  input  wire logic       mclk,         // system clock
  input  wire logic       pulse_go,     // start one low pulse
  input  wire logic [7:0] pulse_len,    // pulse length in clocks
  input  wire logic [5:0] key_out,      // device outputs
  output logic            recal_pin_n,  // recal pin, low active
  output logic [5:0]      key_seen      // last outputs read back
);
  logic [7:0] cnt_q = 8'h00;            // clocks of low left

  // a pulse in flight ignores further requests
  always_ff @(posedge mclk)
  begin
    if (pulse_go && cnt_q == 8'h00)
      cnt_q <= pulse_len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  assign recal_pin_n = (cnt_q == 8'h00);

  // sampled like a microcontroller port, high means touched
  always_ff @(posedge mclk)
    key_seen <= key_out;
endmodule // tkd_partner

// *** tb_touch_key_detect_output.sv ***
// self-checking bench for the touch key detect core
`timescale 1ns/1ps
module tb_touch_key_detect_output;
  import tkd_pkg::*;
  typedef struct packed {
    logic [1:0]  strap;                 // a, b
    logic        sup;                   // suppression on
    logic [23:0] dl;                    // per-key delta, key5 in top nibble
    logic [3:0]  n;                     // ticks to wait
    logic [5:0]  ex;                    // expected outputs
  } tkd_row_s;
  localparam logic [13:0] BASE = 14'h0100; // idle level
  localparam int unsigned TB_CYC = 400;    // short acquisition cycle keeps the run brief
  localparam tkd_row_s ROWS [20] = '{
    '{2'b00, 1'b0, 24'h00_0006, 4'd2, 6'h00},
    '{2'b00, 1'b0, 24'h00_0006, 4'd1, 6'h01},
    '{2'b00, 1'b0, 24'h00_0005, 4'd1, 6'h01},
    '{2'b00, 1'b0, 24'h00_0003, 4'd1, 6'h00},
    '{2'b00, 1'b0, 24'h00_0080, 4'd2, 6'h00},
    '{2'b00, 1'b0, 24'h00_0000, 4'd1, 6'h00},
    '{2'b00, 1'b0, 24'h00_0080, 4'd2, 6'h00},
    '{2'b00, 1'b0, 24'h00_0080, 4'd1, 6'h02},
    '{2'b00, 1'b0, 24'h00_0000, 4'd1, 6'h00},
    '{2'b11, 1'b0, 24'h00_0000, 4'd1, 6'h00},
    '{2'b11, 1'b0, 24'h00_0800, 4'd3, 6'h04},
    '{2'b11, 1'b0, 24'h00_0000, 4'd1, 6'h04},
    '{2'b11, 1'b0, 24'h00_0800, 4'd3, 6'h00},
    '{2'b11, 1'b0, 24'h00_0800, 4'd2, 6'h00},
    '{2'b00, 1'b1, 24'h00_0000, 4'd1, 6'h00},
    '{2'b00, 1'b1, 24'h07_A000, 4'd3, 6'h08},
    '{2'b00, 1'b1, 24'h07_0000, 4'd4, 6'h10},
    '{2'b00, 1'b1, 24'h00_0000, 4'd1, 6'h00},
    '{2'b00, 1'b1, 24'h90_0006, 4'd3, 6'h20},
    '{2'b00, 1'b0, 24'h00_0000, 4'd1, 6'h00}};
  logic                       mclk, srst, burst_busy, suppress_en, pulse_go, cycle_tick, recal_pin_n;
  logic [7:0]                 pulse_len;
  tkd_strap_s                 strap_pins;
  tkd_sample_s [NUM_KEYS-1:0] sample;
  logic [5:0]                 key_out, key_seen;
  int                         failures, cmp_count;

  tkd_core #(.CYCLE_LEN(TB_CYC)) uut (.mclk(mclk), .srst(srst), .recal_pin_n(recal_pin_n), .strap_pins(strap_pins),
                .suppress_en(suppress_en), .sample(sample), .burst_busy(burst_busy),
                .key_out(key_out), .cycle_tick(cycle_tick));
  tkd_partner u_host (.mclk(mclk), .pulse_go(pulse_go), .pulse_len(pulse_len), .key_out(key_out),
                      .recal_pin_n(recal_pin_n), .key_seen(key_seen));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check6(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // levels held steady, valid kept high so every edge latches them
  task automatic set_lv(input logic [23:0] dl);
    for (int k = 0; k < NUM_KEYS; k++)
      sample[k] = '{1'b1, BASE + 14'(dl[4*k +: 4])};
  endtask

  // ends 1 ns after the edge, where inputs may change
  task automatic wait_ticks(input int n);
    int j;
    for (int i = 0; i < n; i++)
    begin
      j = 0;
      do begin @(posedge mclk); j++; end while (!cycle_tick && j < 4 * TB_CYC);
      if (!cycle_tick)
        check6(6'h3f, 6'h00);
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic pin_pulse(input logic [7:0] len);
    pulse_len = len;
    pulse_go  = 1'b1;
    @(posedge mclk);
    #1 pulse_go = 1'b0;
  endtask

  task automatic close_out();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the whole run needs about 50 shortened acquisition cycles
  initial
  begin
    #(64'd100 * 64'(TB_CYC) * 64'd100);
    failures++;
    close_out();
  end

  initial
  begin
    srst = 1'b1;
    burst_busy = 1'b0;
    suppress_en = 1'b0;
    pulse_go = 1'b0;
    pulse_len = 8'h00;
    strap_pins = '{1'b0, 1'b0};
    set_lv(24'h00_0000);
    repeat (8) @(posedge mclk);
    #1 srst = 1'b0;
    wait_ticks(1);
    check6(key_out, 6'h00);
    foreach (ROWS[r])
    begin
      strap_pins  = '{ROWS[r].strap[1], ROWS[r].strap[0]};
      suppress_en = ROWS[r].sup;
      set_lv(ROWS[r].dl);
      wait_ticks(int'(ROWS[r].n));
      check6(key_out, ROWS[r].ex);
    end
    // short pin pulse is refused, a full one clears every key
    set_lv(24'h00_0800);
    wait_ticks(3);
    check6(key_out, 6'h04);
    pin_pulse(8'd20);
    burst_busy = 1'b1;
    repeat (1000) @(posedge mclk);
    #1 burst_busy = 1'b0;
    wait_ticks(1);
    check6(key_out, 6'h04);
    pin_pulse(8'd60);
    wait_ticks(1);
    check6(key_out, 6'h00);
    wait_ticks(1);
    check6(key_seen, 6'h00);
    // reset in mid-run with a key held
    set_lv(24'h00_0F00);
    wait_ticks(3);
    check6(key_seen, 6'h04);
    srst = 1'b1;
    repeat (8) @(posedge mclk);
    #1 check6(key_out, 6'h00);
    srst = 1'b0;
    close_out();
  end
endmodule // tb_touch_key_detect_output

bind tkd_core tkd_props #(.CYCLE_LEN(CYCLE_LEN)) u_props (.mclk(mclk), .srst(srst), .recal_pin_n(recal_pin_n),
  .strap_pins(strap_pins), .suppress_en(suppress_en), .sample(sample),
  .burst_busy(burst_busy), .key_out(key_out), .cycle_tick(cycle_tick));
